/* File: rtl/tqs_defines.vh */
// constants for the queue and stream table setup register bank
// assumes a 32-bit AHB-Lite register port and one 50 MHz clock
`ifndef TQS_DEFINES_VH
`define TQS_DEFINES_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define TQS_OFS_IDR0      8'h00
`define TQS_OFS_CR0       8'h20
`define TQS_OFS_CR0ACK    8'h24
`define TQS_OFS_STATUS    8'h28
`define TQS_OFS_STT_BASE  8'h80
`define TQS_OFS_STT_CFG   8'h88
`define TQS_OFS_CQ_BASE   8'h90
`define TQS_OFS_CQ_WR     8'h98
`define TQS_OFS_CQ_RD     8'h9C
`define TQS_OFS_EQ_BASE   8'hA0
`define TQS_OFS_EQ_WR     8'hA8
`define TQS_OFS_EQ_RD     8'hAC
`define TQS_ADDR_W        8

// ****************************************************************
// field layouts
// ****************************************************************
`define TQS_CR0_EVTQ_BIT  2
`define TQS_CR0_CMDQ_BIT  3
`define TQS_IDR0_COH_BIT  4
`define TQS_ST_CQ_EMPTY   0
`define TQS_ST_EQ_EMPTY   1
`define TQS_STT_CFG_MASK  32'h0003003F
`define TQS_QB_SIZE_MSB   4
`define TQS_QB_SIZE_W     5
`define TQS_QB_SIZE_MAX   5'h13
`define TQS_IDX_W         20
`define TQS_RESET_WORD    32'h00000000

// ****************************************************************
// timing
// ****************************************************************
`define TQS_CLK_NS        20
`define TQS_EN_LAT_NS     80
`define TQS_EN_CNT_W      4

`endif

/* File: rtl/tqs_queue_regs.v */
// one queue: base/size register, write and read indices, enable ack
// assumes writes arrive as single-cycle strobes from the bus slave
`timescale 1ns/1ps
`include "tqs_defines.vh"

module tqs_queue_regs (
  input  wire                   hclk,
  input  wire                   hresetn,
  input  wire                   base_we,
  input  wire                   wr_idx_we,
  input  wire                   rd_idx_we,
  input  wire [31:0]            wdata,
  input  wire                   enable,
  output reg  [31:0]            base_q,
  output reg  [`TQS_IDX_W-1:0]  wr_idx_q,
  output reg  [`TQS_IDX_W-1:0]  rd_idx_q,
  output wire                   empty,
  output reg                    ack_q
);

  localparam integer EN_CYC_I =
    (`TQS_EN_LAT_NS + `TQS_CLK_NS - 1) / `TQS_CLK_NS;
  // latency count cut to the counter width on purpose
  localparam [`TQS_EN_CNT_W-1:0] EN_CYC = EN_CYC_I[`TQS_EN_CNT_W-1:0];

  reg  [`TQS_EN_CNT_W-1:0] cnt_q;
  reg  [`TQS_QB_SIZE_W-1:0] size_w;
  wire [`TQS_IDX_W-1:0]     mask_w;

  // ****************************************************************
  // size limits writable index bits
  // ****************************************************************
  // oversize values clamp so the shift never exceeds the index width
  always @* begin
    if (base_q[`TQS_QB_SIZE_MSB:0] > `TQS_QB_SIZE_MAX) begin
      size_w = `TQS_QB_SIZE_MAX;
    end else begin
      size_w = base_q[`TQS_QB_SIZE_MSB:0];
    end
  end

  // index bits plus one wrap bit above them
  assign mask_w = ~({`TQS_IDX_W{1'b1}} << (size_w + 5'h01));

  assign empty = (wr_idx_q == rd_idx_q);

  // ****************************************************************
  // registers
  // ****************************************************************
  // base is frozen while the queue is live, to keep indices coherent
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      base_q   <= `TQS_RESET_WORD;
      wr_idx_q <= {`TQS_IDX_W{1'b0}};
      rd_idx_q <= {`TQS_IDX_W{1'b0}};
    end else begin
      if (base_we && !enable && !ack_q) begin
        base_q <= wdata;
      end
      if (wr_idx_we) begin
        wr_idx_q <= wdata[`TQS_IDX_W-1:0] & mask_w;
      end
      if (rd_idx_we) begin
        rd_idx_q <= wdata[`TQS_IDX_W-1:0] & mask_w;
      end
    end
  end

  // ****************************************************************
  // enable acknowledge
  // ****************************************************************
  // ack holds until the change has settled for the full latency
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack_q <= 1'b0;
      cnt_q <= {`TQS_EN_CNT_W{1'b0}};
    end else if (enable != ack_q) begin
      if (cnt_q == EN_CYC - 1'b1) begin
        ack_q <= enable;
        cnt_q <= {`TQS_EN_CNT_W{1'b0}};
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end else begin
      cnt_q <= {`TQS_EN_CNT_W{1'b0}};
    end
  end

endmodule // tqs_queue_regs

/* File: rtl/tqs_setup_regs.v */
// queue and stream table setup register bank behind an AHB-Lite port
// assumes one clock, whole-word single transfers, and that the
// table walker presents fetched entry words as one-cycle strobes
//
// Overview of operation
// - The size field of each queue base limits which bits of its read and write indices are writable.
// - A queue is empty whenever its read index equals its write index.
// - A stream table config register holds format and size, and a separate register holds the base.
// - A stream table entry whose valid bit is clear is flagged invalid and never usable.
// - The coherent access flag in identification register zero reads 0 when coherent access is absent.
// - Setting the command queue enable makes the matching ack bit set once enabling completes.
// - The event queue ack bit sets only once event queue enabling completes.
`timescale 1ns/1ps
`include "tqs_defines.vh"

module tqs_setup_regs (
  input  wire                   hclk,
  input  wire                   hresetn,
  input  wire                   hsel,
  input  wire [31:0]            haddr,
  input  wire [1:0]             htrans,
  input  wire                   hwrite,
  input  wire [2:0]             hsize,
  input  wire [31:0]            hwdata,
  input  wire                   hready,
  output reg  [31:0]            hrdata,
  output wire                   hreadyout,
  output wire                   hresp,
  input  wire                   tcu_coherent_ok,
  input  wire                   entry_fetch_valid,
  input  wire                   entry_valid_bit,
  output reg                    entry_usable,
  output reg                    entry_invalid,
  output wire [31:0]            stream_table_base,
  output wire [31:0]            stream_table_config,
  output wire [31:0]            command_queue_base_reg,
  output wire [`TQS_IDX_W-1:0]  command_write_index,
  output wire [`TQS_IDX_W-1:0]  command_read_index,
  output wire                   command_queue_empty,
  output wire                   command_queue_live,
  output wire [31:0]            event_queue_base_reg,
  output wire [`TQS_IDX_W-1:0]  event_write_index,
  output wire [`TQS_IDX_W-1:0]  event_read_index,
  output wire                   event_queue_empty,
  output wire                   event_queue_live
);

  reg                       dp_wr_q;
  reg                       dp_rd_q;
  reg  [`TQS_ADDR_W-1:0]    dp_addr_q;
  reg  [31:0]               cr0_q;
  reg  [31:0]               stt_base_q;
  reg  [31:0]               stt_cfg_q;
  reg  [31:0]               rdata_d;
  wire                      accept;
  wire                      wr_cr0;
  wire                      wr_stt_base;
  wire                      wr_stt_cfg;
  wire                      wr_cq_base;
  wire                      wr_cq_wr;
  wire                      wr_cq_rd;
  wire                      wr_eq_base;
  wire                      wr_eq_wr;
  wire                      wr_eq_rd;
  wire                      cq_ack;
  wire                      eq_ack;
  wire [31:0]               ack_word;
  wire [31:0]               idr0_word;
  wire [31:0]               status_word;

  // ****************************************************************
  // AHB-Lite slave front end
  // ****************************************************************
  // writes take no wait state; reads take one so hrdata is a flop and
  // a read right after a write already sees the written value
  assign accept    = hsel & htrans[1] & hready;
  assign hreadyout = ~dp_rd_q;
  assign hresp     = 1'b0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_q   <= 1'b0;
      dp_rd_q   <= 1'b0;
      dp_addr_q <= {`TQS_ADDR_W{1'b0}};
    end else if (accept) begin
      dp_wr_q   <= hwrite;
      dp_rd_q   <= ~hwrite;
      dp_addr_q <= {haddr[`TQS_ADDR_W-1:2], 2'h0};
    end else begin
      dp_wr_q   <= 1'b0;
      dp_rd_q   <= 1'b0;
    end
  end

  // ****************************************************************
  // write strobes, taken in the data phase
  // ****************************************************************
  assign wr_cr0      = dp_wr_q && (dp_addr_q == `TQS_OFS_CR0);
  assign wr_stt_base = dp_wr_q && (dp_addr_q == `TQS_OFS_STT_BASE);
  assign wr_stt_cfg  = dp_wr_q && (dp_addr_q == `TQS_OFS_STT_CFG);
  assign wr_cq_base  = dp_wr_q && (dp_addr_q == `TQS_OFS_CQ_BASE);
  assign wr_cq_wr    = dp_wr_q && (dp_addr_q == `TQS_OFS_CQ_WR);
  assign wr_cq_rd    = dp_wr_q && (dp_addr_q == `TQS_OFS_CQ_RD);
  assign wr_eq_base  = dp_wr_q && (dp_addr_q == `TQS_OFS_EQ_BASE);
  assign wr_eq_wr    = dp_wr_q && (dp_addr_q == `TQS_OFS_EQ_WR);
  assign wr_eq_rd    = dp_wr_q && (dp_addr_q == `TQS_OFS_EQ_RD);

  // ****************************************************************
  // control and stream table registers
  // ****************************************************************
  // only the two queue enables are kept in control register zero
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cr0_q      <= `TQS_RESET_WORD;
      stt_base_q <= `TQS_RESET_WORD;
      stt_cfg_q  <= `TQS_RESET_WORD;
    end else begin
      if (wr_cr0) begin
        cr0_q <= `TQS_RESET_WORD;
        cr0_q[`TQS_CR0_CMDQ_BIT] <= hwdata[`TQS_CR0_CMDQ_BIT];
        cr0_q[`TQS_CR0_EVTQ_BIT] <= hwdata[`TQS_CR0_EVTQ_BIT];
      end
      if (wr_stt_base) begin
        stt_base_q <= hwdata;
      end
      if (wr_stt_cfg) begin
        stt_cfg_q <= hwdata & `TQS_STT_CFG_MASK;
      end
    end
  end

  assign stream_table_base   = stt_base_q;
  assign stream_table_config = stt_cfg_q;

  // ****************************************************************
  // queues
  // ****************************************************************
  tqs_queue_regs u_cmd_queue (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .base_we   (wr_cq_base),
    .wr_idx_we (wr_cq_wr),
    .rd_idx_we (wr_cq_rd),
    .wdata     (hwdata),
    .enable    (cr0_q[`TQS_CR0_CMDQ_BIT]),
    .base_q    (command_queue_base_reg),
    .wr_idx_q  (command_write_index),
    .rd_idx_q  (command_read_index),
    .empty     (command_queue_empty),
    .ack_q     (cq_ack)
  );

  tqs_queue_regs u_evt_queue (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .base_we   (wr_eq_base),
    .wr_idx_we (wr_eq_wr),
    .rd_idx_we (wr_eq_rd),
    .wdata     (hwdata),
    .enable    (cr0_q[`TQS_CR0_EVTQ_BIT]),
    .base_q    (event_queue_base_reg),
    .wr_idx_q  (event_write_index),
    .rd_idx_q  (event_read_index),
    .empty     (event_queue_empty),
    .ack_q     (eq_ack)
  );

  // a queue is only live for the walker once its ack has set
  assign command_queue_live = cq_ack;
  assign event_queue_live   = eq_ack;

  // ****************************************************************
  // stream table entry validity screen
  // ****************************************************************
  // a cleared valid bit never reaches the translation path as usable
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      entry_usable  <= 1'b0;
      entry_invalid <= 1'b0;
    end else begin
      entry_usable  <= entry_fetch_valid & entry_valid_bit;
      entry_invalid <= entry_fetch_valid & ~entry_valid_bit;
    end
  end

  // ****************************************************************
  // read-only words
  // ****************************************************************
  assign ack_word = {{(31-`TQS_CR0_CMDQ_BIT){1'b0}}, cq_ack, eq_ack,
                     {`TQS_CR0_EVTQ_BIT{1'b0}}};
  assign idr0_word = {{(31-`TQS_IDR0_COH_BIT){1'b0}},
                      tcu_coherent_ok,
                      {`TQS_IDR0_COH_BIT{1'b0}}};
  assign status_word = {30'h00000000, event_queue_empty,
                        command_queue_empty};

  // ****************************************************************
  // read mux, registered into hrdata
  // ****************************************************************
  // unmapped offsets read as zero with an OKAY response
  always @* begin
    case (dp_addr_q)
      `TQS_OFS_IDR0:     rdata_d = idr0_word;
      `TQS_OFS_CR0:      rdata_d = cr0_q;
      `TQS_OFS_CR0ACK:   rdata_d = ack_word;
      `TQS_OFS_STATUS:   rdata_d = status_word;
      `TQS_OFS_STT_BASE: rdata_d = stt_base_q;
      `TQS_OFS_STT_CFG:  rdata_d = stt_cfg_q;
      `TQS_OFS_CQ_BASE:  rdata_d = command_queue_base_reg;
      `TQS_OFS_CQ_WR:    rdata_d = {12'h000, command_write_index};
      `TQS_OFS_CQ_RD:    rdata_d = {12'h000, command_read_index};
      `TQS_OFS_EQ_BASE:  rdata_d = event_queue_base_reg;
      `TQS_OFS_EQ_WR:    rdata_d = {12'h000, event_write_index};
      `TQS_OFS_EQ_RD:    rdata_d = {12'h000, event_read_index};
      default:           rdata_d = `TQS_RESET_WORD;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `TQS_RESET_WORD;
    end else if (dp_rd_q) begin
      hrdata <= rdata_d;
    end
  end

endmodule // tqs_setup_regs

/* File: verification/tqs_setup_regs_sva.sv */
// checker for the setup register bank, bound to its top ports
// assumes single whole-word transfers and hready tied to hreadyout
`timescale 1ns/1ps
`include "tqs_defines.vh"

module tqs_setup_regs_sva (
  input wire [31:0]           haddr,
  input wire                  hclk,
  input wire                  hresetn,
  input wire                  hsel,
  input wire [1:0]            htrans,
  input wire                  hwrite,
  input wire [31:0]           hwdata,
  input wire                  hready,
  input wire [31:0]           hrdata,
  input wire                  hreadyout,
  input wire                  hresp,
  input wire                  tcu_coherent_ok,
  input wire                  entry_fetch_valid,
  input wire                  entry_valid_bit,
  input wire                  entry_usable,
  input wire                  entry_invalid,
  input wire [31:0]           stream_table_config,
  input wire [31:0]           command_queue_base_reg,
  input wire [`TQS_IDX_W-1:0] command_write_index,
  input wire [`TQS_IDX_W-1:0] command_read_index,
  input wire                  command_queue_empty,
  input wire                  command_queue_live,
  input wire [`TQS_IDX_W-1:0] event_write_index,
  input wire [`TQS_IDX_W-1:0] event_read_index,
  input wire                  event_queue_empty,
  input wire                  event_queue_live
);
  // ****
  // data phase tracking, shadow of the two enable bits
  // ****
  reg        dp_q;
  reg        dp_wr_q;
  reg [7:0]  dp_adr_q;
  reg [1:0]  en_q;
  wire       bus_take = hsel && htrans[1] && hready;
  wire       en_wr = dp_q && dp_wr_q && hready && dp_adr_q == `TQS_OFS_CR0;
  wire [4:0] cq_sz = (command_queue_base_reg[4:0] > `TQS_QB_SIZE_MAX) ?
                     `TQS_QB_SIZE_MAX : command_queue_base_reg[4:0];
  // one bit wider so a size of 19 yields all twenty bits
  wire [20:0] cq_m = (21'h1 << (cq_sz + 5'h1)) - 21'h1;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_q <= 1'b0;
      dp_wr_q <= 1'b0;
      dp_adr_q <= 8'h00;
      en_q <= 2'b00;
    end else begin
      if (en_wr)
        en_q <= hwdata[3:2];
      if (hready) begin
        dp_q <= bus_take;
        dp_wr_q <= hwrite;
        dp_adr_q <= haddr[7:0];
      end
    end
  end

  // ****
  // properties
  // ****
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_rd_take; bus_take && !hwrite; endsequence
  sequence s_cmd_on; en_wr && hwdata[3] && !command_queue_live; endsequence
  sequence s_coh_rd;
    dp_q && !dp_wr_q && hreadyout && dp_adr_q == `TQS_OFS_IDR0;
  endsequence

  a_read_two_cycle:
    assert property (s_rd_take |=> !hreadyout ##1 hreadyout)
    else $error("read data phase length wrong");
  a_resp_always_okay:
    assert property (bus_take |=> !hresp) else $error("response not okay");
  a_cmd_empty_eq:
    assert property (command_queue_empty ==
      (command_write_index == command_read_index))
    else $error("command empty flag wrong");
  a_evt_empty_eq:
    assert property (event_queue_empty == (event_read_index ==
      event_write_index)) else $error("event empty flag wrong");
  a_idx_width_mask:
    assert property ($changed(command_write_index) |->
      (command_write_index & ~cq_m[19:0]) == 20'h00000)
    else $error("index bits above size written");
  a_entry_good_pulse:
    assert property (entry_fetch_valid && entry_valid_bit |=>
      entry_usable && !entry_invalid) else $error("valid entry not usable");
  a_entry_bad_pulse:
    assert property (entry_fetch_valid && !entry_valid_bit |=>
      entry_invalid && !entry_usable) else $error("bad entry not flagged");
  a_cmd_ack_time:
    assert property (s_cmd_on |=> !command_queue_live[*3] ##[1:2]
      command_queue_live) else $error("command ack timing wrong");
  a_cmd_ack_lag:
    assert property ($changed(command_queue_live) |-> command_queue_live ==
      en_q[1] && $past(en_q[1], 3) == en_q[1])
    else $error("command ack changed early");
  a_evt_ack_lag:
    assert property ($changed(event_queue_live) |-> event_queue_live ==
      en_q[0] && $past(en_q[0], 3) == en_q[0])
    else $error("event ack changed early");
  a_coh_flag_read:
    assert property (s_coh_rd |-> hrdata[4] == tcu_coherent_ok)
    else $error("coherent flag wrong");
  a_stt_cfg_bits:
    assert property ((stream_table_config & ~`TQS_STT_CFG_MASK) == 32'h0)
    else $error("table config keeps unused bits");
endmodule // tqs_setup_regs_sva

bind tqs_setup_regs tqs_setup_regs_sva sva_u (.*);

/* File: verification/tqs_setup_regs_tb.sv */
// self-checking bench for the setup register bank
// assumes the checker is bound separately; the bench is the bus master
`timescale 1ns/1ps
`include "tqs_defines.vh"

module tqs_setup_regs_tb;
  reg         hclk = 1'b0;
  reg         hresetn = 1'b0;
  reg         hsel = 1'b0;
  reg         hwrite = 1'b0;
  reg         coh_ok = 1'b0;
  reg         fev = 1'b0;
  reg         evb = 1'b0;
  reg  [31:0] haddr = 32'h0;
  reg  [31:0] hwdata = 32'h0;
  reg  [1:0]  htrans = 2'b00;
  reg         rdy_n;
  reg  [31:0] rd_n;
  wire [31:0] hrdata, st_base, st_cfg, cq_base, eq_base;
  wire [`TQS_IDX_W-1:0] cq_wr, cq_rd, eq_wr, eq_rd;
  wire        hreadyout, hresp, ent_ok, ent_bad;
  wire        cq_emp, cq_live, eq_emp, eq_live;
  int         err_total = 0;
  int         checks = 0;

  tqs_setup_regs dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .tcu_coherent_ok(coh_ok), .entry_fetch_valid(fev),
    .entry_valid_bit(evb), .entry_usable(ent_ok), .entry_invalid(ent_bad),
    .stream_table_base(st_base), .stream_table_config(st_cfg),
    .command_queue_base_reg(cq_base), .command_write_index(cq_wr),
    .command_read_index(cq_rd), .command_queue_empty(cq_emp),
    .command_queue_live(cq_live), .event_queue_base_reg(eq_base),
    .event_write_index(eq_wr), .event_read_index(eq_rd),
    .event_queue_empty(eq_emp), .event_queue_live(eq_live));

  always #10 hclk = ~hclk;
  // outputs are taken mid-cycle, clear of the edge that updates them
  always @(negedge hclk) begin
    rdy_n = hreadyout;
    rd_n = hrdata;
  end

  // ****
  // bus and compare tasks
  // ****
  task automatic xfer(input [7:0] a, input w, input [31:0] d,
                      output [31:0] q);
    begin
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h000000, a};
      hwrite <= w;
      do @(posedge hclk); while (rdy_n !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (rdy_n !== 1'b1);
      q = rd_n;
    end
  endtask
  task automatic wr(input [7:0] a, input [31:0] d);
    reg [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask
  task automatic chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      checks++;
      if (g !== e) begin
        err_total++;
        $display("BAD %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task automatic rchk(input [7:0] a, input [31:0] m, input [31:0] e,
                      input string nm);
    reg [31:0] q;
    begin
      xfer(a, 1'b0, 32'h0, q);
      chk(nm, e, q & m);
    end
  endtask
  // polls a bounded number of times, then judges the last value
  task automatic poll(input [7:0] a, input [31:0] m, input [31:0] e,
                      input string nm);
    reg [31:0] q;
    int n;
    begin
      n = 0;
      xfer(a, 1'b0, 32'h0, q);
      while ((q & m) !== e && n < 20) begin
        n++;
        xfer(a, 1'b0, 32'h0, q);
      end
      chk(nm, e, q & m);
    end
  endtask

  // ****
  // scenarios
  // ****
  task automatic t_reset;
    rchk(`TQS_OFS_CR0ACK, 32'hFFFFFFFF, 32'h0, "ack_rst");
    rchk(`TQS_OFS_STATUS, 32'h3, 32'h3, "stat_rst");
    rchk(8'h40, 32'hFFFFFFFF, 32'h0, "unmapped");
    coh_ok <= 1'b1;
    rchk(`TQS_OFS_IDR0, 32'h10, 32'h10, "coh_on");
    coh_ok <= 1'b0;
    rchk(`TQS_OFS_IDR0, 32'h10, 32'h0, "coh_off");
    $display("test reset done");
  endtask
  task automatic t_queue(input [7:0] b, input [31:0] eb, input [4:0] sz);
    reg [31:0] m;
    reg [31:0] p;
    begin
      m = (sz > 5'h13) ? 32'h000FFFFF : (32'h1 << (sz + 5'h1)) - 32'h1;
      wr(b, 32'h40000000 | sz);
      wr(b + 8'h08, 32'h0);
      wr(b + 8'h0C, 32'h0);
      rchk(`TQS_OFS_STATUS, eb, eb, "q_empty");
      wr(b + 8'h08, 32'hFFFFFFFF);
      rchk(b + 8'h08, 32'hFFFFFFFF, m, "wr_mask");
      p = (b == `TQS_OFS_CQ_BASE) ? {12'h000, cq_wr} : {12'h000, eq_wr};
      chk("wr_pin", m, p);
      rchk(`TQS_OFS_STATUS, eb, 32'h0, "q_busy");
      wr(b + 8'h0C, 32'hFFFFFFFF);
      rchk(b + 8'h0C, 32'hFFFFFFFF, m, "rd_mask");
      rchk(`TQS_OFS_STATUS, eb, eb, "q_same");
      rchk(b, 32'hFFFFFFFF, 32'h40000000 | sz, "q_base");
      p = (b == `TQS_OFS_CQ_BASE) ? cq_base : eq_base;
      chk("base_pin", 32'h40000000 | sz, p);
      $display("test queue done");
    end
  endtask
  task automatic t_table;
    wr(`TQS_OFS_STT_CFG, 32'hFFFFFFFF);
    wr(`TQS_OFS_STT_BASE, 32'h12345000);
    // table words settle before any entry is fetched
    @(posedge hclk);
    rchk(`TQS_OFS_STT_CFG, 32'hFFFFFFFF, 32'h0003003F, "cfg");
    chk("base_port", 32'h12345000, st_base);
    $display("test table done");
  endtask
  task automatic t_enable;
    wr(`TQS_OFS_CR0, 32'h8);
    repeat (3) begin
      @(negedge hclk);
      chk("ack_hold", 32'h0, {31'h0, cq_live});
    end
    @(posedge hclk);
    poll(`TQS_OFS_CR0ACK, 32'h8, 32'h8, "cmd_ack");
    // event enable dropped again before it can take effect
    wr(`TQS_OFS_CR0, 32'hC);
    wr(`TQS_OFS_CR0, 32'h8);
    repeat (8) @(posedge hclk);
    rchk(`TQS_OFS_CR0ACK, 32'hC, 32'h8, "evt_back");
    wr(`TQS_OFS_CR0, 32'hC);
    poll(`TQS_OFS_CR0ACK, 32'h4, 32'h4, "evt_ack");
    wr(`TQS_OFS_CQ_BASE, 32'h0);
    rchk(`TQS_OFS_CQ_BASE, 32'hFFFFFFFF, 32'h4000001F, "base_lock");
    wr(`TQS_OFS_CR0, 32'h0);
    poll(`TQS_OFS_CR0ACK, 32'hC, 32'h0, "ack_off");
    $display("test enable done");
  endtask
  task automatic t_entry(input v);
    fev <= 1'b1;
    evb <= v;
    @(posedge hclk);
    fev <= 1'b0;
    evb <= ~v;
    @(negedge hclk);
    chk("usable", {31'h0, v}, {31'h0, ent_ok});
    chk("invalid", {31'h0, ~v}, {31'h0, ent_bad});
    @(posedge hclk);
    $display("test entry done");
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_queue(`TQS_OFS_CQ_BASE, 32'h1, 5'h03);
    t_queue(`TQS_OFS_EQ_BASE, 32'h2, 5'h00);
    t_queue(`TQS_OFS_EQ_BASE, 32'h2, 5'h13);
    t_queue(`TQS_OFS_CQ_BASE, 32'h1, 5'h1F);
    t_table;
    t_enable;
    t_entry(1'b1);
    t_entry(1'b0);
    close_out;
  end
  // the whole run needs well under a thousand cycles
  initial begin
    #200000;
    err_total++;
    close_out;
  end
endmodule // tqs_setup_regs_tb
